//--- common/lcw_pkg.sv
// Constants for the fourth configuration word of the matrix LED driver.
// Notes on behaviour
// - Bit 3 picks the per-channel current ceiling, resets to 0, 0 is the lower and 1 the higher.
// - Bit 14 is the scan-order reversal flag for stacked parts and resets to 1.
// - With the reversal flag clear, the second group of scan lines runs 16 up to 31.
// - With the reversal flag set, the second group of scan lines runs 31 down to 16.
// - Bits 16, 17 and 18 enable fine low-gray compensation for red, green and blue, reset 0.
// - Bits 19, 20 and 21 pick red, green and blue turn-off slew, 0 slow and 1 fast, reset 0.
// - Bits 23-22 and 25-24 pick red and green turn-on slew, reset 01, 00 slowest to 11 fastest.
// - Bit 39 enables decoupling between on and off channels and resets to 0.
// - Bits 43-40 hold the decoupling boost level, reset 1000, codes 0000 to 1111 for levels 1-16.
// - Bits 32, 33 and 34 enable coarse low-gray compensation for red, green and blue, reset 0.
package lcw_pkg;
    localparam int          ADDR_W      = 4;
    localparam int          DATA_W      = 48;
    localparam int          LINE_W      = 5;
    // Register offsets on the plain register port.
    localparam logic [3:0]  ADDR_CONFIG = 4'h0;
    localparam logic [3:0]  ADDR_STATUS = 4'h1;
    // Reset value and writable-bit mask of the configuration word.
    localparam logic [47:0] CFG_RESET   = 48'h0800_0540_4000;
    localparam logic [47:0] CFG_WMASK   = 48'h1fff_0fff_4008;
    // Field positions.
    localparam int          B_CEIL      = 3;
    localparam int          B_SCANREV   = 14;
    localparam int          B_FINE_LO   = 16;
    localparam int          B_OFF_LO    = 19;
    localparam int          B_ON_R_LO   = 22;
    localparam int          B_ON_G_LO   = 24;
    localparam int          B_ON_B_LO   = 26;
    localparam int          B_COARSE_LO = 32;
    localparam int          B_DIM_LO    = 35;
    localparam int          B_DECOUPLE  = 39;
    localparam int          B_BOOST_LO  = 40;
    localparam int          B_BOOST_EN  = 44;
    // Scan line numbering for the two stacked groups of sixteen.
    localparam logic [4:0]  LINE_GROUP2 = 5'h10;
    localparam logic [5:0]  LINE_MIRROR = 6'h2f;
endpackage : lcw_pkg

//--- rtl/lcw_config_word.sv
// Fourth configuration word register with its field outputs and scan mapping.
`timescale 1ns/10ps
module lcw_config_word #(
    parameter int ADDR_W = lcw_pkg::ADDR_W,
    parameter int DATA_W = lcw_pkg::DATA_W,
    parameter int LINE_W = lcw_pkg::LINE_W
) (
    // Clock and reset.
    input  wire logic              CLK_SYS,
    input  wire logic              RST,
    // Register port.
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [DATA_W-1:0] RDATA,
    // Scan line mapping.
    input  wire logic [LINE_W-1:0] LINE_IDX,
    output logic      [LINE_W-1:0] SCAN_LINE,
    // Configuration fields.
    output logic                   CURRENT_CEILING_SELECT,
    output logic                   SCAN_ORDER_REVERSE,
    output logic      [2:0]        LOWGRAY_FINE_ENABLE,
    output logic      [2:0]        TURNOFF_SLEW,
    output logic      [1:0]        RED_TURNON_SLEW,
    output logic      [1:0]        GREEN_TURNON_SLEW,
    output logic      [1:0]        BLUE_TURNON_SLEW,
    output logic      [2:0]        LOWGRAY_COARSE_ENABLE,
    output logic      [3:0]        FIRST_LINE_DIM,
    output logic                   ONOFF_DECOUPLING_ENABLE,
    output logic      [3:0]        DECOUPLING_BOOST_LEVEL,
    output logic                   DECOUPLING_BOOST_ENABLE
);
    logic [DATA_W-1:0] cfg_q;
    logic [DATA_W-1:0] cfg_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              cfg_hit;
    logic              status_hit;

    // Address decode.
    always_comb
    begin
        cfg_hit    = 1'b0;
        status_hit = 1'b0;
        if (ADDR == ADDR_W'(lcw_pkg::ADDR_CONFIG))
            cfg_hit = 1'b1;
        else if (ADDR == ADDR_W'(lcw_pkg::ADDR_STATUS))
            status_hit = 1'b1;
    end

    // Only writable bits take the written value; reserved bits keep their fixed value.
    always_comb
    begin
        cfg_d = cfg_q;
        if (WR && cfg_hit)
        begin
            cfg_d = (WDATA & lcw_pkg::CFG_WMASK)
                  | (lcw_pkg::CFG_RESET & ~lcw_pkg::CFG_WMASK);
        end
    end

    // Read data stand only in the cycle after the read strobe; unmapped reads return zero.
    always_comb
    begin
        rdata_d = '0;
        if (RD && cfg_hit)
            rdata_d = cfg_q;
        else if (RD && status_hit)
            rdata_d = {{(DATA_W-LINE_W){1'b0}}, SCAN_LINE};
    end

    // Register the configuration word and the read data.
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            cfg_q   <= lcw_pkg::CFG_RESET;
            rdata_q <= '0;
        end
        else
        begin
            cfg_q   <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    // Field outputs are slices of the configuration flip-flops.
    assign RDATA                   = rdata_q;
    assign CURRENT_CEILING_SELECT  = cfg_q[lcw_pkg::B_CEIL];
    assign SCAN_ORDER_REVERSE      = cfg_q[lcw_pkg::B_SCANREV];
    assign LOWGRAY_FINE_ENABLE     = cfg_q[lcw_pkg::B_FINE_LO +: 3];
    assign TURNOFF_SLEW            = cfg_q[lcw_pkg::B_OFF_LO +: 3];
    assign RED_TURNON_SLEW         = cfg_q[lcw_pkg::B_ON_R_LO +: 2];
    assign GREEN_TURNON_SLEW       = cfg_q[lcw_pkg::B_ON_G_LO +: 2];
    assign BLUE_TURNON_SLEW        = cfg_q[lcw_pkg::B_ON_B_LO +: 2];
    assign LOWGRAY_COARSE_ENABLE   = cfg_q[lcw_pkg::B_COARSE_LO +: 3];
    assign FIRST_LINE_DIM          = cfg_q[lcw_pkg::B_DIM_LO +: 4];
    assign ONOFF_DECOUPLING_ENABLE = cfg_q[lcw_pkg::B_DECOUPLE];
    assign DECOUPLING_BOOST_LEVEL  = cfg_q[lcw_pkg::B_BOOST_LO +: 4];
    assign DECOUPLING_BOOST_ENABLE = cfg_q[lcw_pkg::B_BOOST_EN];

    // Scan line mapper steered by the reversal flag.
    lcw_scan_map #(
        .LINE_W      (LINE_W)
    ) u_scan_map (
        .clk         (CLK_SYS),
        .rst         (RST),
        .line_idx    (LINE_IDX),
        .reverse     (cfg_q[lcw_pkg::B_SCANREV]),
        .phys_line_q (SCAN_LINE)
    );

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    sequence s_cfg_write;
        WR && cfg_hit;
    endsequence

    property p_ceiling_write;
        s_cfg_write |=> CURRENT_CEILING_SELECT == $past(WDATA[lcw_pkg::B_CEIL]);
    endproperty
    a_ceiling_write: assert property (p_ceiling_write)
        else $error("Current ceiling select did not follow the write.");

    property p_scanrev_reset;
        $fell(RST) |-> SCAN_ORDER_REVERSE && !CURRENT_CEILING_SELECT;
    endproperty
    a_scanrev_reset: assert property (p_scanrev_reset)
        else $error("Reversal flag or ceiling select wrong after reset.");

    property p_fine_write;
        s_cfg_write |=> LOWGRAY_FINE_ENABLE == $past(WDATA[lcw_pkg::B_FINE_LO +: 3]);
    endproperty
    a_fine_write: assert property (p_fine_write)
        else $error("Fine enables did not follow the write.");

    property p_turnoff_hold;
        !(WR && cfg_hit) |=> $stable(TURNOFF_SLEW);
    endproperty
    a_turnoff_hold: assert property (p_turnoff_hold)
        else $error("Turn-off slew changed without a write.");

    property p_turnon_reset;
        $fell(RST) |-> RED_TURNON_SLEW == 2'h1 && GREEN_TURNON_SLEW == 2'h1;
    endproperty
    a_turnon_reset: assert property (p_turnon_reset)
        else $error("Turn-on slew reset value wrong.");

    property p_reserved_fixed;
        ((cfg_q ^ lcw_pkg::CFG_RESET) & ~lcw_pkg::CFG_WMASK) == '0;
    endproperty
    a_reserved_fixed: assert property (p_reserved_fixed)
        else $error("Reserved bit moved from its fixed value.");

    property p_decouple_write;
        s_cfg_write |=> ONOFF_DECOUPLING_ENABLE == $past(WDATA[lcw_pkg::B_DECOUPLE]);
    endproperty
    a_decouple_write: assert property (p_decouple_write)
        else $error("Decoupling enable did not follow the write.");

    property p_boost_reset;
        $fell(RST) |->
            DECOUPLING_BOOST_LEVEL == lcw_pkg::CFG_RESET[lcw_pkg::B_BOOST_LO +: 4];
    endproperty
    a_boost_reset: assert property (p_boost_reset)
        else $error("Boost level reset value wrong.");

    property p_coarse_write;
        s_cfg_write |=> LOWGRAY_COARSE_ENABLE == $past(WDATA[lcw_pkg::B_COARSE_LO +: 3]);
    endproperty
    a_coarse_write: assert property (p_coarse_write)
        else $error("Coarse enables did not follow the write.");

    property p_read_once;
        (RD && cfg_hit) |=> RDATA == $past(cfg_q) ##1 (RDATA == '0 || $past(RD));
    endproperty
    a_read_once: assert property (p_read_once)
        else $error("Read data wrong or held too long.");

    // A write lands on the reversal flag in the next cycle.
    property p_scanrev_write;
        s_cfg_write |=> SCAN_ORDER_REVERSE == $past(WDATA[lcw_pkg::B_SCANREV]);
    endproperty
    a_scanrev_write: assert property (p_scanrev_write)
        else $error("Reversal flag did not follow the write.");

    // Colour enables and turn-off slews leave reset cleared.
    property p_fine_reset;
        $fell(RST) |-> LOWGRAY_FINE_ENABLE == '0 && TURNOFF_SLEW == '0
            && LOWGRAY_COARSE_ENABLE == '0 && !ONOFF_DECOUPLING_ENABLE;
    endproperty
    a_fine_reset: assert property (p_fine_reset)
        else $error("Colour enables or slews not clear after reset.");

    // A write lands on the turn-off slews in the next cycle.
    property p_turnoff_write;
        s_cfg_write |=> TURNOFF_SLEW == $past(WDATA[lcw_pkg::B_OFF_LO +: 3]);
    endproperty
    a_turnoff_write: assert property (p_turnoff_write)
        else $error("Turn-off slews did not follow the write.");

    // A write lands on the red and green turn-on slews in the next cycle.
    property p_turnon_write;
        s_cfg_write |=> RED_TURNON_SLEW == $past(WDATA[lcw_pkg::B_ON_R_LO +: 2])
            && GREEN_TURNON_SLEW == $past(WDATA[lcw_pkg::B_ON_G_LO +: 2]);
    endproperty
    a_turnon_write: assert property (p_turnon_write)
        else $error("Turn-on slews did not follow the write.");

    // Without a write to the word, nothing in it may move.
    property p_config_hold;
        !(WR && cfg_hit) |=> $stable(cfg_q);
    endproperty
    a_config_hold: assert property (p_config_hold)
        else $error("Configuration word changed without a write to it.");

    // A write lands on the boost level in the next cycle.
    property p_boost_write;
        s_cfg_write |=> DECOUPLING_BOOST_LEVEL == $past(WDATA[lcw_pkg::B_BOOST_LO +: 4]);
    endproperty
    a_boost_write: assert property (p_boost_write)
        else $error("Boost level did not follow the write.");

    // The status word reports the mapped line of the read cycle.
    property p_status_read;
        (RD && status_hit) |=> RDATA == {{(DATA_W-LINE_W){1'b0}}, $past(SCAN_LINE)};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("Status read did not return the mapped line.");
endmodule : lcw_config_word

//--- rtl/lcw_scan_map.sv
// Maps a logical scan line index to the physical line for stacked parts.
`timescale 1ns/10ps
module lcw_scan_map #(
    parameter int LINE_W = lcw_pkg::LINE_W
) (
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              rst,
    // Mapping request.
    input  wire logic [LINE_W-1:0] line_idx,
    input  wire logic              reverse,
    // Mapped line, registered.
    output logic      [LINE_W-1:0] phys_line_q
);
    logic [LINE_W-1:0] phys_line_d;
    logic [5:0]        mirrored;

    // Second group counts down from the top when reversed.
    always_comb
    begin
        mirrored    = lcw_pkg::LINE_MIRROR - {1'b0, line_idx};
        phys_line_d = line_idx;
        if ((line_idx >= lcw_pkg::LINE_GROUP2) && reverse)
        begin
            phys_line_d = mirrored[LINE_W-1:0];
        end
    end

    // Register the mapped line.
    always_ff @(posedge clk)
    begin
        if (rst)
            phys_line_q <= '0;
        else
            phys_line_q <= phys_line_d;
    end

    // Upper-group request with a given direction.
    sequence s_up_req;
        line_idx >= lcw_pkg::LINE_GROUP2 && !reverse;
    endsequence
    sequence s_down_req;
        line_idx >= lcw_pkg::LINE_GROUP2 && reverse;
    endsequence

    property p_ascending;
        @(posedge clk) disable iff (rst)
        s_up_req |=> phys_line_q == $past(line_idx);
    endproperty
    a_ascending: assert property (p_ascending)
        else $error("Second group not ascending with reversal clear.");

    property p_descending;
        @(posedge clk) disable iff (rst)
        s_down_req |=> (phys_line_q + $past(line_idx)) == 5'(lcw_pkg::LINE_MIRROR);
    endproperty
    a_descending: assert property (p_descending)
        else $error("Second group not descending with reversal set.");
endmodule : lcw_scan_map

//--- verification/test_lcw_config_word.sv
// Self-checking bench for the fourth configuration word register and its scan mapping.
`timescale 1ns/10ps
module test_lcw_config_word;
    // Reset image: reversal flag set, turn-on slews 01, boost level 1000, all else clear.
    localparam logic [47:0] RST_IMG = 48'h0800_0540_4000;
    localparam logic [47:0] WMASK   = lcw_pkg::CFG_WMASK;
    logic        clk_sys;
    logic        rst;
    logic [3:0]  addr;
    logic [47:0] wdata;
    logic        wr;
    logic        rd;
    logic [47:0] rdata;
    logic [4:0]  line_idx;
    logic [4:0]  scan_line;
    logic        ceil;
    logic        rev;
    logic        dec;
    logic        bst;
    logic [2:0]  fine;
    logic [2:0]  off;
    logic [2:0]  coarse;
    logic [1:0]  on_r;
    logic [1:0]  on_g;
    logic [1:0]  on_b;
    logic [3:0]  dim;
    logic [3:0]  lvl;
    logic [47:0] exp_rd_q[$];
    logic [4:0]  exp_ln_q[$];
    logic [47:0] exp_fd_q[$];
    logic        fld_chk;
    logic        rd_seen;
    logic        sc_seen;
    logic        scan_on;
    logic        armed;
    logic [31:0] seed;
    logic [47:0] v;
    integer      miscompares;
    integer      checks_done;
    integer      cycles;

    lcw_config_word dut (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .LINE_IDX(line_idx), .SCAN_LINE(scan_line),
        .CURRENT_CEILING_SELECT(ceil), .SCAN_ORDER_REVERSE(rev), .LOWGRAY_FINE_ENABLE(fine),
        .TURNOFF_SLEW(off), .RED_TURNON_SLEW(on_r), .GREEN_TURNON_SLEW(on_g),
        .BLUE_TURNON_SLEW(on_b), .LOWGRAY_COARSE_ENABLE(coarse), .FIRST_LINE_DIM(dim),
        .ONOFF_DECOUPLING_ENABLE(dec), .DECOUPLING_BOOST_LEVEL(lvl),
        .DECOUPLING_BOOST_ENABLE(bst));

    // Free-running 100 MHz clock.
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Xorshift step for the write data.
    function automatic logic [31:0] xs_next(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs_next

    // Prints the verdict once and ends the run.
    task print_verdict();
        if (miscompares == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    // Compares a 48-bit word.
    task cmp_word(input logic [47:0] exp, input logic [47:0] got);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : cmp_word

    // Compares a mapped scan line.
    task cmp_line(input logic [4:0] exp, input logic [4:0] got);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : cmp_line

    // One bus cycle; a read also notes the word expected in the following cycle.
    task bus(input logic w, input logic r, input logic [3:0] a, input logic [47:0] d,
             input logic [47:0] e);
        @(posedge clk_sys);
        wr      <= w;
        rd      <= r;
        addr    <= a;
        wdata   <= d;
        fld_chk <= 1'b0;
        if (r)
            exp_rd_q.push_back(e);
    endtask : bus

    // Idles the bus for a cycle and notes the field image expected over that cycle.
    task chk_fields(input logic [47:0] e);
        @(posedge clk_sys);
        wr      <= 1'b0;
        rd      <= 1'b0;
        fld_chk <= 1'b1;
        exp_fd_q.push_back(e);
    endtask : chk_fields

    // Watches read data and scan lines against the oldest notes, and cuts a hang short.
    always @(posedge clk_sys)
    begin
        rd_seen <= rd;
        sc_seen <= scan_on;
        if (rd_seen)
            cmp_word(exp_rd_q.pop_front(), rdata);
        else if (armed)
            cmp_word(48'h0, rdata);
        if (sc_seen)
            cmp_line(exp_ln_q.pop_front(), scan_line);
        if (fld_chk)
            cmp_word(exp_fd_q.pop_front(), {3'h0, bst, lvl, dec, dim, coarse, 4'h0, on_b, on_g,
                     on_r, off, fine, 1'b0, rev, 10'h0, ceil, 3'h0});
        cycles = cycles + 1;
        if (cycles == 2000)
        begin
            miscompares = miscompares + 1;
            print_verdict();
        end
    end

    // Main sequence: reset image, refused writes, field coverage, then scan mapping.
    initial
    begin
        {wr, rd, scan_on, armed, rd_seen, sc_seen, fld_chk} = 7'h0;
        rst         = 1'b1;
        addr        = 4'h0;
        wdata       = 48'h0;
        line_idx    = 5'h0;
        seed        = 32'h91151e39;
        miscompares = 0;
        checks_done = 0;
        cycles      = 0;
        repeat (4) @(posedge clk_sys);
        rst   <= 1'b0;
        armed <= 1'b1;
        chk_fields(RST_IMG);
        bus(1'b0, 1'b1, 4'h0, 48'h0, RST_IMG);
        bus(1'b0, 1'b1, 4'h9, 48'h0, 48'h0);
        bus(1'b1, 1'b0, 4'h1, {48{1'b1}}, 48'h0);
        bus(1'b1, 1'b0, 4'hc, {48{1'b1}}, 48'h0);
        bus(1'b0, 1'b1, 4'h0, 48'h0, RST_IMG);
        bus(1'b1, 1'b0, 4'h0, {48{1'b1}}, 48'h0);
        bus(1'b0, 1'b1, 4'h0, 48'h0, WMASK);
        chk_fields(WMASK);
        // Random words with every red and green turn-on slew code forced in turn.
        for (int k = 0; k < 4; k++)
        begin
            seed        = xs_next(seed);
            v[31:0]     = seed;
            seed        = xs_next(seed);
            v[47:32]    = seed[15:0];
            v[25:22]    = {2{k[1:0]}};
            bus(1'b1, 1'b0, 4'h0, v, 48'h0);
            bus(1'b0, 1'b1, 4'h0, 48'h0, v & WMASK);
            chk_fields(v & WMASK);
        end
        // Walks all 32 logical lines with the reversal flag clear, then set.
        for (int r = 0; r < 2; r++)
        begin
            bus(1'b1, 1'b0, 4'h0, (r == 1) ? 48'h4000 : 48'h0, 48'h0);
            bus(1'b0, 1'b0, 4'h0, 48'h0, 48'h0);
            for (int i = 0; i < 32; i++)
            begin
                @(posedge clk_sys);
                line_idx <= i[4:0];
                scan_on  <= 1'b1;
                exp_ln_q.push_back((r == 1 && i >= 16) ? 5'(47 - i) : i[4:0]);
            end
            @(posedge clk_sys);
            scan_on <= 1'b0;
            bus(1'b0, 1'b1, 4'h1, 48'h0, {43'h0, (r == 1) ? 5'h10 : 5'h1f});
            bus(1'b0, 1'b0, 4'h0, 48'h0, 48'h0);
        end
        repeat (3) @(posedge clk_sys);
        print_verdict();
    end
endmodule : test_lcw_config_word
